// ---- include/sac_defs.vh ----
// constants for the successive-approximation converter control block
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SAC_ADDR_CTRL      16'h0070
`define SAC_ADDR_RES_HIGH  16'h0071
`define SAC_ADDR_RES_LOW   16'h0072
`define SAC_CTRL_RESET     8'h00
`define SAC_RES_RESET      10'h000

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define SAC_BIT_DONE       7
`define SAC_BIT_SPEED      6
`define SAC_BIT_ON         5
`define SAC_SEL_HI         3
`define SAC_SEL_LO         0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SAC_SAMPLE_CLKS    4'h3
`define SAC_RES_BITS       4'hA
`define SAC_DIV4_LAST      2'h3
`define SAC_DIV2_LAST      2'h1
`define SAC_FULL_SCALE     10'h3FF
`define SAC_ZERO_SCALE     10'h000

`endif

// ---- core/sac_clk_div.v ----
// conversion clock enable divider
`timescale 1ns/1ns
module sac_clk_div (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       run_i,
	input  wire       fast_i,
	output wire       tick_o
);
`include "sac_defs.vh"

	reg  [1:0] cnt_q;
	wire [1:0] last;

	assign last   = fast_i ? `SAC_DIV2_LAST : `SAC_DIV4_LAST;
	assign tick_o = run_i && (cnt_q == last);

	always @(posedge clk_i) begin
		if (rst_i || !run_i || tick_o) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
		end
	end
endmodule // sac_clk_div

// ---- core/sac_sar_core.v ----
// successive-approximation sequencer: sampling then one trial per bit
`timescale 1ns/1ns
module sac_sar_core (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       run_i,
	input  wire       restart_i,
	input  wire       tick_i,
	input  wire       cmp_i,
	output wire       sample_o,
	output wire [9:0] trial_o,
	output reg        done_o,
	output wire [9:0] result_o
);
`include "sac_defs.vh"

	localparam ST_IDLE   = 2'h0;
	localparam ST_SAMPLE = 2'h1;
	localparam ST_CONV   = 2'h2;

	reg [1:0] state_q;
	reg [3:0] cnt_q;
	reg [9:0] sar_q;
	reg [9:0] res_q;
	reg [9:0] bit_q;

	assign sample_o = (state_q == ST_SAMPLE);
	assign trial_o  = sar_q | bit_q;
	assign result_o = res_q;

	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			sar_q   <= 10'h000;
			bit_q   <= 10'h000;
			res_q   <= `SAC_RES_RESET;
		end else if (!run_i || restart_i) begin
			// abort drops the partial result; restart resumes from sampling
			state_q <= run_i ? ST_SAMPLE : ST_IDLE;
			cnt_q   <= 4'h0;
			sar_q   <= 10'h000;
			bit_q   <= 10'h000;
		end else if (tick_i) begin
			case (state_q)
			ST_IDLE: begin
				state_q <= ST_SAMPLE;
				cnt_q   <= 4'h0;
			end
			ST_SAMPLE: begin
				if (cnt_q == `SAC_SAMPLE_CLKS - 4'h1) begin
					state_q <= ST_CONV;
					cnt_q   <= 4'h0;
					bit_q   <= 10'h200;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
			ST_CONV: begin
				// comparator saturation makes over-range 3FF and under-range 000
				if (cmp_i) begin
					sar_q <= sar_q | bit_q;
				end
				bit_q <= bit_q >> 1;
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == `SAC_RES_BITS - 4'h1) begin
					res_q   <= cmp_i ? (sar_q | bit_q) : sar_q;
					done_o  <= 1'b1;
					state_q <= ST_SAMPLE;
					cnt_q   <= 4'h0;
					sar_q   <= 10'h000;
					bit_q   <= 10'h000;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // sac_sar_core

// ---- core/sac_adc_ctrl.v ----
// converter control top: register slave, sequencing and result registers
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module sac_adc_ctrl (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [15:0] addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [7:0]  rdata_o,
	input  wire        halt_i,
	input  wire        cmp_i,
	output wire [3:0]  input_select_o,
	output wire        converter_on_o,
	output wire        sample_o,
	output wire [9:0]  trial_o
);
`include "sac_defs.vh"

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	reg        done_q;
	reg        speed_q;
	reg        on_q;
	reg  [3:0] sel_q;
	reg        halt_s1_q;
	reg        halt_s2_q;
	wire [9:0] res;
	wire       conv_done;
	wire       tick;
	wire       wr_ctrl;
	wire       rd_high;
	wire       sel_change;
	wire       run;

	assign wr_ctrl    = wr_i && (addr_i == `SAC_ADDR_CTRL);
	assign rd_high    = rd_i && (addr_i == `SAC_ADDR_RES_HIGH);
	assign sel_change = wr_ctrl && (wdata_i[`SAC_SEL_HI:`SAC_SEL_LO] != sel_q);
	// wait mode has no input here, so conversions carry on through it
	assign run = on_q && !halt_s2_q;

	assign input_select_o = sel_q;
	assign converter_on_o = run;

	// halt comes from the power controller's domain, so synchronise it
	always @(posedge clk_i) begin
		if (rst_i) begin
			halt_s1_q <= 1'b0;
			halt_s2_q <= 1'b0;
		end else begin
			halt_s1_q <= halt_i;
			halt_s2_q <= halt_s1_q;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			speed_q <= 1'b0;
			on_q    <= 1'b0;
			sel_q   <= 4'h0;
		end else if (wr_ctrl) begin
			// done bit and reserved bit four ignore written values
			speed_q <= wdata_i[`SAC_BIT_SPEED];
			on_q    <= wdata_i[`SAC_BIT_ON];
			sel_q   <= wdata_i[`SAC_SEL_HI:`SAC_SEL_LO];
		end
	end

	// ----------------------------------------------------------------
	// done flag
	// ----------------------------------------------------------------
	// a completion in the same cycle as a plain clear wins, except when the
	// write changes the input: that completion belonged to the old input
	always @(posedge clk_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
		end else if (sel_change) begin
			done_q <= 1'b0;
		end else if (conv_done) begin
			done_q <= 1'b1;
		end else if (rd_high || wr_ctrl) begin
			done_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// converter
	// ----------------------------------------------------------------
	sac_clk_div u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (run),
		.fast_i (speed_q),
		.tick_o (tick)
	);

	sac_sar_core u_sar (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (run),
		.restart_i (sel_change),
		.tick_i    (tick),
		.cmp_i     (cmp_i),
		.sample_o  (sample_o),
		.trial_o   (trial_o),
		.done_o    (conv_done),
		.result_o  (res)
	);

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// both result bytes track the same live register, no pair latch
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
			`SAC_ADDR_CTRL: begin
				rdata_o <= {done_q, speed_q, on_q, 1'b0, sel_q};
			end
			`SAC_ADDR_RES_HIGH: begin
				rdata_o <= res[9:2];
			end
			`SAC_ADDR_RES_LOW: begin
				rdata_o <= {6'h00, res[1:0]};
			end
			default: begin
				rdata_o <= 8'h00;
			end
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule // sac_adc_ctrl

// ---- sim/sac_adc_ctrl_sva.sv ----
// port checks for the converter control block
`timescale 1ns/1ns
module sac_adc_ctrl_sva (
	input wire        clk_i,
	input wire        rst_i,
	input wire [15:0] addr_i,
	input wire [7:0]  wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [7:0]  rdata_o,
	input wire        halt_i,
	input wire [3:0]  input_select_o,
	input wire        converter_on_o,
	input wire        sample_o
);
// copy of write data, so no slice goes through $past
reg [7:0] wd_q;
always @(posedge clk_i) begin
	wd_q <= wdata_i;
end
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_wr_ctrl;
	wr_i && addr_i == 16'h0070;
endsequence
sequence s_rd_ctrl;
	rd_i && addr_i == 16'h0070;
endsequence
sequence s_halt3;
	halt_i [*3];
endsequence
a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
	else $error("idle read data");
a_low_pad: assert property (rd_i && addr_i == 16'h0072 |=> rdata_o[7:2] == 6'h00)
	else $error("low pad bits");
a_unmapped: assert property (rd_i && (addr_i < 16'h0070 || addr_i > 16'h0072)
	|=> rdata_o == 8'h00) else $error("unmapped read");
a_rsvd_bit: assert property (s_rd_ctrl |=> !rdata_o[4])
	else $error("reserved bit set");
a_sel_write: assert property (s_wr_ctrl |=> input_select_o == wd_q[3:0])
	else $error("input select");
a_on_write: assert property (s_wr_ctrl ##0 (!halt_i && !$past(halt_i))
	|=> converter_on_o == wd_q[5]) else $error("on bit");
a_halt_off: assert property (s_halt3 |-> !converter_on_o)
	else $error("on in halt");
a_off_idle: assert property (!converter_on_o [*2] |-> !sample_o)
	else $error("sampling while off");
endmodule // sac_adc_ctrl_sva
bind sac_adc_ctrl sac_adc_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i),
	.input_select_o(input_select_o), .converter_on_o(converter_on_o), .sample_o(sample_o));

// ---- sim/sac_adc_ctrl_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ns
module sac_adc_ctrl_tb;
reg        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, halt_i = 1'b0, cmp_i = 1'b0;
reg [15:0] addr_i = 16'h0000;
reg [7:0]  wdata_i = 8'h00;
reg [9:0]  vin = 10'h000;
reg [7:0]  d, l, h;
wire [7:0] rdata_o;
wire [3:0] input_select_o;
wire       converter_on_o, sample_o;
wire [9:0] trial_o;
integer    err_total = 0, cmp_count = 0, seed = 16865, cyc = 0, i, n;
sac_adc_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .cmp_i(cmp_i),
	.input_select_o(input_select_o), .converter_on_o(converter_on_o),
	.sample_o(sample_o), .trial_o(trial_o));
always #5 clk_i = ~clk_i;
// comparator a clock late is safe: every trial stands two clocks or more
always @(posedge clk_i) cmp_i <= (vin >= trial_o);
always @(posedge clk_i) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		err_total = err_total + 1;
		print_verdict;
	end
end
// ----------
// bus, check and verdict tasks
// ----------
task wr(input [15:0] a, input [7:0] v);
begin
	@(posedge clk_i);
	addr_i <= a;
	wdata_i <= v;
	wr_i <= 1'b1;
	@(posedge clk_i);
	wr_i <= 1'b0;
end
endtask
task rd(input [15:0] a, output [7:0] v);
begin
	@(posedge clk_i);
	addr_i <= a;
	rd_i <= 1'b1;
	@(posedge clk_i);
	rd_i <= 1'b0;
	#1 v = rdata_o;
end
endtask
task chk(input [9:0] s, input [9:0] e);
begin
	cmp_count = cmp_count + 1;
	if (s !== e) begin
		err_total = err_total + 1;
		$display("wrong value at %0t: %h expected %h", $time, s, e);
	end
end
endtask
task print_verdict;
begin
	$display("mismatches %0d of %0d compares", err_total, cmp_count);
	if (err_total == 0 && cmp_count > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
end
endtask
initial begin
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	for (i = 0; i < 4; i = i + 1) begin
		rd(16'h0070 + i[15:0], d);
		chk(d, 10'h000);
	end
	// each pass after the first picks a new input, so its write restarts a conversion
	for (i = 0; i < 16; i = i + 1) begin
		vin = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : $random(seed);
		n = $random(seed) & 1;
		wr(16'h0070, {1'b1, n[0], 2'b11, i[3:0]});
		rd(16'h0070, d);
		chk(d, {2'b00, n[0], 2'b10, i[3:0]});
		chk(input_select_o, i[3:0]);
		repeat (40) if (!d[7]) rd(16'h0070, d);
		rd(16'h0072, l);
		rd(16'h0071, h);
		chk({h, l[1:0]}, vin);
		chk(l[7:2], 10'h000);
		rd(16'h0070, d);
		chk(d[7], 10'h000);
	end
	for (i = 0; i < 2; i = i + 1) begin
		wr(16'h0070, {1'b0, i[0], 6'h25});
		@(posedge sample_o);
		@(posedge sample_o);
		n = cyc;
		@(posedge sample_o);
		chk(10'(cyc - n), i[0] ? 10'h01A : 10'h034);
	end
	// a plain control write and an input change must each drop a standing done flag
	for (i = 0; i < 2; i = i + 1) begin
		d = 8'h00;
		repeat (40) if (!d[7]) rd(16'h0070, d);
		chk(d[7], 10'h001);
		wr(16'h0070, {1'b0, 1'b1, 2'b10, 4'h5 + i[3:0]});
		rd(16'h0070, d);
		chk(d[7], 10'h000);
	end
	@(posedge clk_i);
	halt_i <= 1'b1;
	repeat (5) @(posedge clk_i);
	#1 chk(converter_on_o, 10'h000);
	chk(sample_o, 10'h000);
	@(posedge clk_i);
	halt_i <= 1'b0;
	repeat (4) @(posedge clk_i);
	#1 chk(converter_on_o, 10'h001);
	wr(16'h0070, 8'h05);
	rd(16'h0071, h);
	wr(16'h0071, ~h);
	wr(16'h0072, 8'hFF);
	rd(16'h0071, d);
	chk(d, h);
	chk(converter_on_o, 10'h000);
	// reset with the converter switched off must wipe a non-zero result and the control bits
	@(posedge clk_i);
	rst_i <= 1'b1;
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	for (i = 0; i < 3; i = i + 1) begin
		rd(16'h0070 + i[15:0], d);
		chk(d, 10'h000);
	end
	chk(converter_on_o, 10'h000);
	chk(input_select_o, 10'h000);
	print_verdict;
end
endmodule // sac_adc_ctrl_tb
